// *** hdl/ebc_pkg.sv ***
// Shared constants and types of the external bus control block
package ebc_pkg;

  // Core clock period and derived release drive time
  localparam int CLK_PERIOD_NS = 5;
  localparam int RELEASE_DRIVE_NS = 5;
  localparam int RELEASE_CYCLES_I =
    (RELEASE_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RELEASE_CYCLES =
    (RELEASE_CYCLES_I < 1) ? 4'h1 : RELEASE_CYCLES_I[3:0];

  // Encoding of the instruction class on the access port
  localparam int OP_W = 3;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_BIT_SET = 3'h1;
  localparam logic [2:0] OP_CLEAR = 3'h2;
  localparam logic [2:0] OP_BIT_CHANGE = 3'h3;
  localparam logic [2:0] OP_OTHER = 3'h4;

  // Reset values of the pin drivers
  localparam logic BUSY_OUT_RST = 1'b1;
  localparam logic BUSY_OE_RST = 1'b0;
  localparam logic REQ_N_RST = 1'b1;
  localparam logic LOCK_N_RST = 1'b1;
  localparam logic STROBE_N_RST = 1'b1;
  localparam logic STROBE_OE_RST = 1'b0;
  localparam logic BUS_CLK_RST = 1'b0;
  localparam logic BUS_CLK_OE_RST = 1'b0;

  // Mastership states
  typedef enum logic [2:0] {
    ARB_IDLE,
    ARB_REQUEST,
    ARB_OWN,
    ARB_PARK,
    ARB_RELEASE
  } ebc_arb_t;

endpackage

// *** hdl/ebc_link_if.sv ***
// Carrier between the core-side control and the bus clock domain
`timescale 1ns/1ps
interface ebc_link_if;
  logic master;
  logic clk_enable;
  logic bus_clk;
  logic bus_clk_oe;
  logic bus_clk_n;
  logic bus_clk_n_oe;

  modport core (output master, output clk_enable);
  modport link (input master, input clk_enable, output bus_clk,
    output bus_clk_oe, output bus_clk_n, output bus_clk_n_oe);
endinterface

// *** hdl/ebc_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
module ebc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // Destination clock
  input wire logic rstn, // Async reset, active low
  input wire logic d, // Level from another domain
  output logic q // Synchronised level
);
  logic meta_r;
  logic sync_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

// *** hdl/ebc_bclk_gen.sv ***
// Bus clock and its inverse, generated on the link clock
`timescale 1ns/1ps
module ebc_bclk_gen (
  input wire logic link_clk, // Phase-advanced clock from the PLL
  input wire logic rstn, // Async reset, active low
  ebc_link_if.link lnk // Levels in, pin drivers out
);
  logic master_s;
  logic enable_s;
  logic clk_r;
  logic clk_nxt;
  logic oe_r;
  logic oe_nxt;
  logic inv_r;
  logic inv_nxt;

  ebc_sync #(.RST_VAL(1'b0)) u_sync_master (
    .clk(link_clk),
    .rstn(rstn),
    .d(lnk.master),
    .q(master_s)
  );

  ebc_sync #(.RST_VAL(1'b0)) u_sync_enable (
    .clk(link_clk),
    .rstn(rstn),
    .d(lnk.clk_enable),
    .q(enable_s)
  );

  always_comb
  begin
    // Toggles only as master with the enable bit set
    clk_nxt = (master_s && enable_s) ? ~clk_r : ebc_pkg::BUS_CLK_RST;
    oe_nxt = master_s;
    inv_nxt = ~clk_nxt;
  end

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_r <= ebc_pkg::BUS_CLK_RST;
      oe_r <= ebc_pkg::BUS_CLK_OE_RST;
      inv_r <= ~ebc_pkg::BUS_CLK_RST;
    end
    else
    begin
      clk_r <= clk_nxt;
      oe_r <= oe_nxt;
      inv_r <= inv_nxt;
    end
  end

  // Edge lead on the core clock comes from the PLL phase of link_clk
  assign lnk.bus_clk = clk_r;
  assign lnk.bus_clk_oe = oe_r;
  assign lnk.bus_clk_n = inv_r;
  assign lnk.bus_clk_n_oe = oe_r;
endmodule

// *** hdl/ebc_top.sv ***
// External bus control: busy-line sharing, bus lock, strobe and bus clock
//
// How it works
// - Busy line changes only with core clock.
// - Take bus only after busy released.
// - Master may park holding busy asserted.
// - Release busy: drive high, then let go.
// - Lock from cycle start to write end.
// - Lock stays off without external lock cycles or lock-hold bit.
// - Auto lock only bit-set/clear/bit-change external.
// - Lock-hold bit forces lock output asserted.
// - Strobe driven as master, else by enable.
// - Bus clock toggles as master when enabled.
// - Bus clock leads core clock by quarter.
// - Inverse bus clock only while master.
`timescale 1ns/1ps
module ebc_top (
  input wire logic clk, // Core clock, 200 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic link_clk, // PLL clock for the bus clock pins
  output logic core_clock_out, // Core clock to the pin
  input wire logic bus_need, // Core has external accesses pending
  input wire logic bus_grant_n_in, // Grant pin, active low
  output logic bus_request_line_n, // Request pin, active low
  input wire logic bus_busy_line_n_in, // Busy pin level
  output logic bus_busy_line_n_out, // Busy pin drive value
  output logic bus_busy_line_n_oe, // Busy pin drive enable
  output logic is_master, // Device owns the bus
  input wire logic rmw_start, // Start of a read-modify-write access
  input wire logic [2:0] rmw_op, // Instruction class of that access
  input wire logic rmw_external, // Access targets external memory
  input wire logic rmw_write_end, // End of the write bus cycle
  input wire logic lock_hold_bit, // Software lock-hold control
  output logic bus_lock_line_n, // Lock pin, active low
  input wire logic strobe_req_n, // Column strobe from DRAM control
  input wire logic mastership_enable_bit, // Keep strobe driven
  output logic col_strobe_n_out, // Column strobe pin value
  output logic col_strobe_n_oe, // Column strobe pin enable
  input wire logic bus_clock_enable_bit, // Bus clock enable
  output logic bus_clock_out, // Bus clock pin value
  output logic bus_clock_out_oe, // Bus clock pin enable
  output logic bus_clock_n_out, // Inverse bus clock pin value
  output logic bus_clock_n_oe // Inverse bus clock pin enable
);

  ebc_link_if lnk ();

  // Pin inputs, synchronised before any decision
  logic grant_s;
  logic busy_free_s;

  ebc_sync #(.RST_VAL(1'b1)) u_sync_grant (
    .clk(clk),
    .rstn(rstn),
    .d(bus_grant_n_in),
    .q(grant_s)
  );

  ebc_sync #(.RST_VAL(1'b1)) u_sync_busy (
    .clk(clk),
    .rstn(rstn),
    .d(bus_busy_line_n_in),
    .q(busy_free_s)
  );

  // Grant pin is active low; only the second flop is read
  logic granted;
  logic busy_released;
  assign granted = ~grant_s;
  assign busy_released = busy_free_s;

  // Read-modify-write lock
  // Lock pin is a flop so it never glitches between cycles
  logic lock_r;
  logic lock_nxt;
  logic lock_n_r;
  logic lock_n_nxt;
  logic auto_lock_op;
  logic lock_set;

  always_comb
  begin
    auto_lock_op = (rmw_op == ebc_pkg::OP_BIT_SET) ||
      (rmw_op == ebc_pkg::OP_CLEAR) ||
      (rmw_op == ebc_pkg::OP_BIT_CHANGE);
    lock_set = rmw_start && rmw_external && auto_lock_op;
    lock_nxt = lock_r;
    // A new start in the ending cycle keeps the lock: set wins
    if (rmw_write_end)
    begin
      lock_nxt = 1'b0;
    end
    if (lock_set)
    begin
      lock_nxt = 1'b1;
    end
    // Pin asserts already in the start cycle's next edge
    lock_n_nxt = ~(lock_nxt || lock_hold_bit);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_r <= 1'b0;
      lock_n_r <= ebc_pkg::LOCK_N_RST;
    end
    else
    begin
      lock_r <= lock_nxt;
      lock_n_r <= lock_n_nxt;
    end
  end

  assign bus_lock_line_n = lock_n_r;

  // Mastership state machine
  // Count kept wide enough for a longer drive at faster clocks
  ebc_pkg::ebc_arb_t state_r;
  ebc_pkg::ebc_arb_t state_nxt;
  logic [3:0] rel_cnt_r;
  logic [3:0] rel_cnt_nxt;
  logic req_n_r;
  logic req_n_nxt;
  logic busy_out_r;
  logic busy_out_nxt;
  logic busy_oe_r;
  logic busy_oe_nxt;
  logic master_r;
  logic master_nxt;
  logic hold_lock;

  // Never give the bus away inside an indivisible access
  assign hold_lock = lock_r || lock_hold_bit;

  always_comb
  begin
    state_nxt = state_r;
    rel_cnt_nxt = rel_cnt_r;
    unique case (state_r)
      ebc_pkg::ARB_IDLE:
      begin
        if (bus_need)
        begin
          state_nxt = ebc_pkg::ARB_REQUEST;
        end
      end
      ebc_pkg::ARB_REQUEST:
      begin
        if (!bus_need)
        begin
          state_nxt = ebc_pkg::ARB_IDLE;
        end
        else if (granted && busy_released)
        begin
          state_nxt = ebc_pkg::ARB_OWN;
        end
      end
      ebc_pkg::ARB_OWN:
      begin
        if (!bus_need)
        begin
          state_nxt = ebc_pkg::ARB_PARK;
        end
      end
      ebc_pkg::ARB_PARK:
      begin
        // Reuse without arbitration while the grant stays
        if (bus_need)
        begin
          state_nxt = ebc_pkg::ARB_OWN;
        end
        else if (!granted && !hold_lock)
        begin
          state_nxt = ebc_pkg::ARB_RELEASE;
          rel_cnt_nxt = ebc_pkg::RELEASE_CYCLES;
        end
      end
      ebc_pkg::ARB_RELEASE:
      begin
        // Drive high first so the pull-up never starts from low
        rel_cnt_nxt = rel_cnt_r - 4'h1;
        if (rel_cnt_r == 4'h1)
        begin
          state_nxt = ebc_pkg::ARB_IDLE;
        end
      end
      default:
      begin
        // Illegal code: fall back to idle with the busy line let go
        state_nxt = ebc_pkg::ARB_IDLE;
      end
    endcase

    // Pin drivers follow the next state, so they move on core edges
    req_n_nxt = (state_nxt != ebc_pkg::ARB_REQUEST);
    master_nxt = (state_nxt == ebc_pkg::ARB_OWN) ||
      (state_nxt == ebc_pkg::ARB_PARK);
    busy_out_nxt = ~master_nxt;
    busy_oe_nxt = master_nxt ||
      (state_nxt == ebc_pkg::ARB_RELEASE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ebc_pkg::ARB_IDLE;
      rel_cnt_r <= 4'h0;
      req_n_r <= ebc_pkg::REQ_N_RST;
      busy_out_r <= ebc_pkg::BUSY_OUT_RST;
      busy_oe_r <= ebc_pkg::BUSY_OE_RST;
      master_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rel_cnt_r <= rel_cnt_nxt;
      req_n_r <= req_n_nxt;
      busy_out_r <= busy_out_nxt;
      busy_oe_r <= busy_oe_nxt;
      master_r <= master_nxt;
    end
  end

  assign bus_request_line_n = req_n_r;
  assign bus_busy_line_n_out = busy_out_r;
  assign bus_busy_line_n_oe = busy_oe_r;
  assign is_master = master_r;

  // Column address strobe
  // Next-state master keeps strobe and ownership on one edge
  logic strobe_r;
  logic strobe_nxt;
  logic strobe_oe_r;
  logic strobe_oe_nxt;

  always_comb
  begin
    // Off the bus with the enable set, hold the strobe deasserted
    strobe_nxt = master_nxt ? strobe_req_n : ebc_pkg::STROBE_N_RST;
    strobe_oe_nxt = master_nxt || mastership_enable_bit;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strobe_r <= ebc_pkg::STROBE_N_RST;
      strobe_oe_r <= ebc_pkg::STROBE_OE_RST;
    end
    else
    begin
      strobe_r <= strobe_nxt;
      strobe_oe_r <= strobe_oe_nxt;
    end
  end

  assign col_strobe_n_out = strobe_r;
  assign col_strobe_n_oe = strobe_oe_r;

  // Bus clock: levels cross to the link domain and are resynchronised
  // Only flop outputs cross, never combinational terms
  logic clk_en_r;
  logic clk_en_nxt;

  always_comb
  begin
    clk_en_nxt = bus_clock_enable_bit;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_en_r <= 1'b0;
    end
    else
    begin
      clk_en_r <= clk_en_nxt;
    end
  end

  assign lnk.master = master_r;
  assign lnk.clk_enable = clk_en_r;

  ebc_bclk_gen u_bclk (
    .link_clk(link_clk),
    .rstn(rstn),
    .lnk(lnk.link)
  );

  assign bus_clock_out = lnk.bus_clk;
  assign bus_clock_out_oe = lnk.bus_clk_oe;
  assign bus_clock_n_out = lnk.bus_clk_n;
  assign bus_clock_n_oe = lnk.bus_clk_n_oe;

  // The core clock itself goes to its pin unchanged
  assign core_clock_out = clk;

endmodule

// *** sim/ebc_checker.sv ***
// Pin-level assertions for the external bus control block
`timescale 1ns/1ps
module ebc_checker (
  input wire logic clk, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic link_clk, // Bus clock source
  input wire logic bus_busy_line_n_in, // Busy wire
  input wire logic bus_busy_line_n_out, // Busy value
  input wire logic bus_busy_line_n_oe, // Busy enable
  input wire logic is_master, // Ownership
  input wire logic rmw_start, // Access start
  input wire logic [2:0] rmw_op, // Access class
  input wire logic rmw_external, // External access
  input wire logic rmw_write_end, // Write end
  input wire logic lock_hold_bit, // Lock hold
  input wire logic bus_lock_line_n, // Lock pin
  input wire logic mastership_enable_bit, // Strobe keep
  input wire logic col_strobe_n_oe, // Strobe enable
  input wire logic bus_clock_out, // Bus clock
  input wire logic bus_clock_out_oe, // Bus clock enable
  input wire logic bus_clock_n_out, // Inverse clock
  input wire logic bus_clock_n_oe // Inverse enable
);
  logic lock_go;
  assign lock_go = rmw_start && rmw_external &&
    rmw_op >= ebc_pkg::OP_BIT_SET && rmw_op <= ebc_pkg::OP_BIT_CHANGE;

  lock_set_a: assert property (@(posedge clk) disable iff (!rstn)
    lock_go |=> !bus_lock_line_n) else $error("lock not set");
  lock_drop_a: assert property (@(posedge clk) disable iff (!rstn)
    rmw_write_end && !lock_go && !lock_hold_bit |=> bus_lock_line_n)
    else $error("lock not dropped");
  lock_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    lock_hold_bit |=> !bus_lock_line_n) else $error("hold ignored");
  lock_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_lock_line_n && !lock_go && !lock_hold_bit |=> bus_lock_line_n)
    else $error("stray lock");
  busy_own_a: assert property (@(posedge clk) disable iff (!rstn)
    is_master |-> bus_busy_line_n_oe && !bus_busy_line_n_out)
    else $error("busy not held");
  take_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(is_master) |-> $past(bus_busy_line_n_in, 3))
    else $error("took busy bus");
  busy_free_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(is_master) |-> bus_busy_line_n_oe && bus_busy_line_n_out
    ##1 !bus_busy_line_n_oe) else $error("bad busy release");
  strobe_on_a: assert property (@(posedge clk) disable iff (!rstn)
    is_master && $past(is_master) |-> col_strobe_n_oe)
    else $error("strobe not driven");
  strobe_off_a: assert property (@(posedge clk) disable iff (!rstn)
    !is_master && !$past(is_master) && !mastership_enable_bit &&
    !$past(mastership_enable_bit) |-> !col_strobe_n_oe)
    else $error("strobe not floated");
  clk_pair_a: assert property (@(posedge link_clk) disable iff (!rstn)
    bus_clock_n_oe == bus_clock_out_oe &&
    (!bus_clock_n_oe || bus_clock_n_out == !bus_clock_out))
    else $error("inverse clock wrong");
endmodule

bind ebc_top ebc_checker chk_u (.clk, .rstn, .link_clk, .bus_busy_line_n_in,
  .bus_busy_line_n_out, .bus_busy_line_n_oe, .is_master, .rmw_start, .rmw_op,
  .rmw_external, .rmw_write_end, .lock_hold_bit, .bus_lock_line_n,
  .mastership_enable_bit, .col_strobe_n_oe, .bus_clock_out, .bus_clock_out_oe,
  .bus_clock_n_out, .bus_clock_n_oe);

// *** sim/ebc_partner.sv ***
// Other bus master with its arbiter, sharing the busy wire
`timescale 1ns/1ps
module ebc_partner (
  input wire logic clk, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic other_need, // Other master wants the bus
  input wire logic req_n, // Device request
  input wire logic busy_n, // Resolved busy wire
  output logic grant_n, // Grant to the device
  output logic busy_n_out, // Busy drive value
  output logic busy_n_oe // Busy drive enable
);
  logic own_r;
  logic rel_r;
  assign busy_n_oe = own_r | rel_r;
  assign busy_n_out = !own_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      grant_n <= 1'b1;
      own_r <= 1'b0;
      rel_r <= 1'b0;
    end
    else
    begin
      // Grant withheld while this side owns or releases
      if (other_need)
        grant_n <= 1'b1;
      else if (!req_n && !own_r && !rel_r)
        grant_n <= 1'b0;
      own_r <= other_need && grant_n && (own_r || busy_n);
      rel_r <= own_r && !other_need;
    end
  end
endmodule

// *** sim/tb_external_bus_control.sv ***
// Self-checking bench for the external bus control block
`timescale 1ns/1ps
module tb_external_bus_control;
  logic clk, link_clk, rstn = 0, bus_need = 0, other_need = 0;
  logic rmw_start = 0, rmw_external = 0, rmw_write_end = 0, hold_bit = 0;
  logic [2:0] rmw_op = 3'h0;
  logic strobe_req_n = 1, me_bit = 0, bc_en = 1;
  logic grant_n, req_n, busy_wire, busy_out, busy_oe, master, p_out, p_oe;
  logic lock_n, cs_out, cs_oe, bc, bc_oe, bcn, bcn_oe, cco;
  int fail_count = 0;
  int samples_checked = 0;
  // Pull-up holds the busy wire high when nobody drives it
  assign busy_wire = busy_oe ? busy_out : (p_oe ? p_out : 1'b1);

  ebc_top dut_u (.clk(clk), .rstn(rstn), .link_clk(link_clk),
    .core_clock_out(cco), .bus_need(bus_need), .bus_grant_n_in(grant_n),
    .bus_request_line_n(req_n), .bus_busy_line_n_in(busy_wire),
    .bus_busy_line_n_out(busy_out), .bus_busy_line_n_oe(busy_oe),
    .is_master(master), .rmw_start(rmw_start), .rmw_op(rmw_op),
    .rmw_external(rmw_external), .rmw_write_end(rmw_write_end),
    .lock_hold_bit(hold_bit), .bus_lock_line_n(lock_n),
    .strobe_req_n(strobe_req_n), .mastership_enable_bit(me_bit),
    .col_strobe_n_out(cs_out), .col_strobe_n_oe(cs_oe),
    .bus_clock_enable_bit(bc_en), .bus_clock_out(bc), .bus_clock_out_oe(bc_oe),
    .bus_clock_n_out(bcn), .bus_clock_n_oe(bcn_oe));
  ebc_partner other_u (.clk(clk), .rstn(rstn), .other_need(other_need),
    .req_n(req_n), .busy_n(busy_wire), .grant_n(grant_n),
    .busy_n_out(p_out), .busy_n_oe(p_oe));

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    link_clk = 0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  task automatic chk(input string what, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic links(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic wait_master(input logic v);
    for (int k = 0; k < 40 && master !== v; k++)
      cyc(1);
    chk("mastership", master, v);
  endtask

  task automatic t_arb();
    logic b;
    @(posedge clk);
    other_need <= 1'b1;
    bus_need <= 1'b1;
    cyc(20);
    chk("request", req_n, 1'b0);
    chk("no takeover", master, 1'b0);
    @(posedge clk);
    other_need <= 1'b0;
    wait_master(1'b1);
    chk("busy driven low", busy_wire, 1'b0);
    chk("strobe enable", cs_oe, 1'b1);
    @(posedge clk);
    strobe_req_n <= 1'b0;
    cyc(2);
    chk("strobe value", cs_out, 1'b0);
    links(4);
    for (int k = 0; k < 4; k++)
    begin
      b = bc;
      links(1);
      chk("bus clock toggles", bc, ~b);
      chk("inverse clock", bcn, ~bc);
      chk("inverse enable", bcn_oe, 1'b1);
    end
    @(posedge clk);
    bc_en <= 1'b0;
    links(4);
    b = bc;
    links(1);
    chk("bus clock stopped", bc, b);
    @(posedge clk);
    bc_en <= 1'b1;
    bus_need <= 1'b0;
    strobe_req_n <= 1'b1;
    cyc(20);
    chk("parked", master, 1'b1);
    chk("parked busy", busy_wire, 1'b0);
    @(posedge clk);
    hold_bit <= 1'b1;
    other_need <= 1'b1;
    cyc(10);
    chk("held by lock", master, 1'b1);
    @(posedge clk);
    hold_bit <= 1'b0;
    wait_master(1'b0);
    chk("release high", busy_oe & busy_out, 1'b1);
    cyc(1);
    chk("release let go", busy_oe, 1'b0);
    chk("strobe floated", cs_oe, 1'b0);
    @(posedge clk);
    me_bit <= 1'b1;
    cyc(2);
    chk("strobe kept", cs_oe & cs_out, 1'b1);
    @(posedge clk);
    me_bit <= 1'b0;
    links(5);
    chk("bus clock floated", bc_oe, 1'b0);
    chk("inverse floated", bcn_oe, 1'b0);
    @(posedge clk);
    other_need <= 1'b0;
    cyc(4);
  endtask

  task automatic t_lock();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      rmw_start <= 1'b1;
      rmw_op <= (i == 5) ? ebc_pkg::OP_BIT_SET : i[2:0];
      rmw_external <= (i != 5);
      @(posedge clk);
      rmw_start <= 1'b0;
      cyc(3);
      chk("lock during gap", lock_n, !(i >= 1 && i <= 3));
      @(posedge clk);
      rmw_write_end <= 1'b1;
      @(posedge clk);
      rmw_write_end <= 1'b0;
      #1;
      chk("lock after write", lock_n, 1'b1);
    end
    @(posedge clk);
    rmw_start <= 1'b1;
    rmw_op <= ebc_pkg::OP_CLEAR;
    rmw_external <= 1'b1;
    rmw_write_end <= 1'b1;
    @(posedge clk);
    rmw_start <= 1'b0;
    rmw_write_end <= 1'b0;
    #1;
    chk("start beats write end", lock_n, 1'b0);
    @(posedge clk);
    rmw_write_end <= 1'b1;
    @(posedge clk);
    rmw_write_end <= 1'b0;
    #1;
    chk("lock cleared", lock_n, 1'b1);
    @(posedge clk);
    hold_bit <= 1'b1;
    cyc(2);
    chk("lock by hold", lock_n, 1'b0);
    @(posedge clk);
    hold_bit <= 1'b0;
    cyc(3);
    chk("lock idle", lock_n, 1'b1);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    chk("reset request", req_n, 1'b1);
    chk("reset busy", busy_oe | master, 1'b0);
    chk("reset lock", lock_n, 1'b1);
    chk("reset strobe", cs_oe, 1'b0);
    chk("reset bus clock", bc_oe | bcn_oe, 1'b0);
    chk("core clock high", cco, 1'b1);
    #2;
    chk("core clock low", cco, 1'b0);
    t_lock();
    t_arb();
    finish_test();
  end
  // Whole run takes well under 20 us
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule
